// [rtl/flash_status_consts.svh]
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH

`define CLK_MHZ 250
`define PROT_TOGGLE_US 280
`define SUSPEND_LATENCY_US 20
`define BANK_MSB 23
`define BANK_LSB 20
`define SECTOR_MSB 23
`define SECTOR_LSB 16
`define POLL_BIT 7
`define BUSY_TOGGLE_BIT 6
`define SUSP_TOGGLE_BIT 2
`define DATA_POLL_SRC_BIT 7
`define ERASE_DATA 16'hffff
`define BOUNDARY_LOW 7'h00
`define BOUNDARY_WAIT 4'h2
`define WAIT_CODE_DEFAULT 4'hd
`define WAIT_FIRST_LOW 4'h2
`define WAIT_FIRST_HIGH 4'h8

`endif

// [rtl/flash_status_pkg.sv]
package flash_status_pkg;

	typedef enum logic [4:0] {
		ENG_IDLE = 5'b00001,
		ENG_RUN = 5'b00010,
		ENG_HALTING = 5'b00100,
		ENG_SUSP = 5'b01000,
		ENG_PROT = 5'b10000
	} eng_state_t;

	typedef enum logic [3:0] {
		B_IDLE = 4'b0001,
		B_WAIT = 4'b0010,
		B_DATA = 4'b0100,
		B_BOUND = 4'b1000
	} burst_state_t;

	typedef struct packed {
		eng_state_t eng;
		logic [16:0] timer;
		logic [23:0] opAddr;
		logic [15:0] opData;
		logic [2:0] avdS;
		logic [2:0] ceS;
		logic [2:0] oeS;
		logic [2:0] weS;
		logic [1:0][7:0] hiS;
		logic [1:0][15:0] adqS;
		logic [23:0] capAddr;
		logic t6;
		logic t2;
		logic [15:0] dout;
		logic doe;
		logic cmdWr;
		logic [23:0] cmdAddr;
		logic [15:0] cmdData;
		logic runQ;
		logic suspQ;
	} core_t;

	typedef struct packed {
		burst_state_t bst;
		logic [3:0] cnt;
		logic [23:0] addr;
		logic [23:0] fetch;
		logic [15:0] dout;
		logic doe;
		logic rdy;
		logic rdyOe;
		logic t6;
		logic t2;
		logic isStatus;
		logic [1:0] runS;
		logic [1:0] suspS;
		logic [1:0] modeS;
		logic [1:0] earlyS;
		logic [1:0] pollS;
		logic [1:0][3:0] codeS;
		logic [1:0][3:0] bankS;
		logic [1:0][7:0] sectS;
	} link_t;

endpackage : flash_status_pkg

// [rtl/flash_status_poll_burst_latency.sv]
// Notes on behaviour
// - an asynchronous access, command cycles included, takes its address on the rising edge of the address strobe.
// - status takes two reads at a valid address, and every such read is answered with status.
// - the polling bit is the inverse of the written data while the algorithm runs and true data afterwards.
// - the busy toggle bit flips on each status read while the algorithm runs and stops once it ends.
// - the erase-suspend toggle bit flips only on reads inside the erase-suspended sector.
// - ready comes with the data when the timing select is 0 and one clock earlier when it is 1.
// - a burst adds latency when it crosses a 128-word boundary, word 000000h counting as one.
// - the four-bit wait code puts first data on edge 2 to 7 or 8 to 13 after capture, 1101 default.
// - a synchronous burst takes its start address on a clock edge and counts wait states from it.
// - reads of banks other than the busy one return array data while the busy bank returns status.
// - erase of a protected sector toggles status for 280 us, then returns to read mode unerased.
`include "flash_status_consts.svh"
`timescale 1ns/100ps
module flash_status_poll_burst_latency #(
	parameter int PROTECT_CYCLES = `PROT_TOGGLE_US * `CLK_MHZ,
	parameter int SUSPEND_CYCLES = `SUSPEND_LATENCY_US * `CLK_MHZ
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic linkClk,
	input wire logic address_valid_strobe_n,
	input wire logic chipSelectN,
	input wire logic outputEnableN,
	input wire logic writeEnableN,
	input wire logic [7:0] addrHi,
	input wire logic [15:0] adqIn,
	output logic [15:0] asyncAdqOut,
	output logic asyncAdqOe,
	output logic [15:0] burstAdqOut,
	output logic burstAdqOe,
	output logic rdyOut,
	output logic rdyOe,
	input wire logic syncMode,
	input wire logic ready_timing_select,
	input wire logic wait_code_bit3,
	input wire logic wait_code_bit2,
	input wire logic wait_code_bit1,
	input wire logic wait_code_bit0,
	output logic [23:0] arrayAddr,
	input wire logic [15:0] arrayData,
	output logic [23:0] burstArrayAddr,
	input wire logic [15:0] burstArrayData,
	output logic cmdWrite,
	output logic [23:0] cmdAddr,
	output logic [15:0] cmdData,
	input wire logic opStart,
	input wire logic opIsErase,
	input wire logic opProtected,
	input wire logic [23:0] opAddr,
	input wire logic [15:0] opData,
	input wire logic opFinished,
	input wire logic suspendReq,
	input wire logic resumeReq,
	output logic opRunning,
	output logic opSuspended
);

	flash_status_pkg::core_t st_ff;
	flash_status_pkg::core_t nxt_st;
	flash_status_pkg::link_t lk_ff;
	flash_status_pkg::link_t nxt_lk;

	function automatic logic [15:0] statusWord(input logic poll, input logic t6, input logic t2);
		logic [15:0] w;
		w = 16'h0000;
		w[`POLL_BIT] = poll;
		w[`BUSY_TOGGLE_BIT] = t6;
		w[`SUSP_TOGGLE_BIT] = t2;
		return w;
	endfunction : statusWord

	// edge after capture that carries the first word; reserved codes fall back to default
	function automatic logic [3:0] firstEdge(input logic [3:0] code);
		logic [3:0] c;
		c = (code[2:1] == 2'b11) ? `WAIT_CODE_DEFAULT : code;
		if (c[3]) begin
			return c - `WAIT_FIRST_HIGH + `WAIT_FIRST_HIGH;
		end else begin
			return c + `WAIT_FIRST_LOW;
		end
	endfunction : firstEdge

	logic running;
	logic halted;
	logic busyHit;
	logic suspHit;
	logic avdRise;
	logic readStart;
	logic weRise;
	logic pollInv;

	// core domain: embedded algorithm engine and the asynchronous pin path
	always_comb begin
		nxt_st = st_ff;
		nxt_st.avdS = {st_ff.avdS[1:0], address_valid_strobe_n};
		nxt_st.ceS = {st_ff.ceS[1:0], chipSelectN};
		nxt_st.oeS = {st_ff.oeS[1:0], outputEnableN};
		nxt_st.weS = {st_ff.weS[1:0], writeEnableN};
		nxt_st.hiS = {st_ff.hiS[0], addrHi};
		nxt_st.adqS = {st_ff.adqS[0], adqIn};
		nxt_st.cmdWr = 1'b0;
		running = (st_ff.eng == flash_status_pkg::ENG_RUN)
			|| (st_ff.eng == flash_status_pkg::ENG_HALTING)
			|| (st_ff.eng == flash_status_pkg::ENG_PROT);
		halted = (st_ff.eng == flash_status_pkg::ENG_SUSP);
		pollInv = ~st_ff.opData[`DATA_POLL_SRC_BIT];
		avdRise = st_ff.avdS[1] & ~st_ff.avdS[2];
		readStart = ~st_ff.ceS[1] & ~st_ff.oeS[1] & ~(~st_ff.ceS[2] & ~st_ff.oeS[2]);
		weRise = st_ff.weS[1] & ~st_ff.weS[2] & ~st_ff.ceS[1];
		busyHit = running
			&& st_ff.capAddr[`BANK_MSB:`BANK_LSB] == st_ff.opAddr[`BANK_MSB:`BANK_LSB];
		suspHit = halted
			&& st_ff.capAddr[`SECTOR_MSB:`SECTOR_LSB] == st_ff.opAddr[`SECTOR_MSB:`SECTOR_LSB];
		if (avdRise) begin
			nxt_st.capAddr = {st_ff.hiS[1], st_ff.adqS[1]};
		end
		if (weRise) begin
			nxt_st.cmdWr = 1'b1;
			nxt_st.cmdAddr = st_ff.capAddr;
			nxt_st.cmdData = st_ff.adqS[1];
		end
		if (readStart && busyHit) begin
			nxt_st.t6 = ~st_ff.t6;
		end
		if (readStart && suspHit) begin
			nxt_st.t2 = ~st_ff.t2;
		end
		// every read in the busy bank or the erase-suspended sector answers with status, array data elsewhere
		if (busyHit || suspHit) begin
			nxt_st.dout = statusWord(pollInv, st_ff.t6, st_ff.t2);
		end else begin
			nxt_st.dout = arrayData;
		end
		nxt_st.doe = ~syncMode & ~st_ff.ceS[1] & ~st_ff.oeS[1] & st_ff.weS[1];
		unique case (st_ff.eng)
			flash_status_pkg::ENG_IDLE: begin
				if (opStart) begin
					nxt_st.opAddr = opAddr;
					nxt_st.opData = opIsErase ? `ERASE_DATA : opData;
					if (opIsErase && opProtected) begin
						nxt_st.eng = flash_status_pkg::ENG_PROT;
						nxt_st.timer = 17'(PROTECT_CYCLES - 1);
					end else begin
						nxt_st.eng = flash_status_pkg::ENG_RUN;
					end
				end
			end
			flash_status_pkg::ENG_RUN: begin
				if (opFinished) begin
					nxt_st.eng = flash_status_pkg::ENG_IDLE;
				end else if (suspendReq) begin
					nxt_st.eng = flash_status_pkg::ENG_HALTING;
					nxt_st.timer = 17'(SUSPEND_CYCLES - 1);
				end
			end
			flash_status_pkg::ENG_HALTING: begin
				// the algorithm keeps running until the halt lands, never past the latency
				if (opFinished) begin
					nxt_st.eng = flash_status_pkg::ENG_IDLE;
				end else if (st_ff.timer == 17'h00000) begin
					nxt_st.eng = flash_status_pkg::ENG_SUSP;
				end else begin
					nxt_st.timer = st_ff.timer - 17'h00001;
				end
			end
			flash_status_pkg::ENG_SUSP: begin
				if (resumeReq) begin
					nxt_st.eng = flash_status_pkg::ENG_RUN;
				end
			end
			flash_status_pkg::ENG_PROT: begin
				if (st_ff.timer == 17'h00000) begin
					nxt_st.eng = flash_status_pkg::ENG_IDLE;
				end else begin
					nxt_st.timer = st_ff.timer - 17'h00001;
				end
			end
		endcase
		// registered decode: status pins and the link synchronisers see clean flops
		nxt_st.runQ = nxt_st.eng == flash_status_pkg::ENG_RUN
			|| nxt_st.eng == flash_status_pkg::ENG_HALTING
			|| nxt_st.eng == flash_status_pkg::ENG_PROT;
		nxt_st.suspQ = nxt_st.eng == flash_status_pkg::ENG_SUSP;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.eng <= flash_status_pkg::ENG_IDLE;
			st_ff.avdS <= 3'h7;
			st_ff.ceS <= 3'h7;
			st_ff.oeS <= 3'h7;
			st_ff.weS <= 3'h7;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign asyncAdqOut = st_ff.dout;
	assign asyncAdqOe = st_ff.doe;
	assign arrayAddr = st_ff.capAddr;
	assign cmdWrite = st_ff.cmdWr;
	assign cmdAddr = st_ff.cmdAddr;
	assign cmdData = st_ff.cmdData;
	assign opRunning = st_ff.runQ;
	assign opSuspended = st_ff.suspQ;

	// link domain: burst pins are timed by the host to linkClk, so they are sampled
	// directly; engine flags and config cross by two flops. bank, sector and poll
	// fields are written on the same clk edge as the run flag rises and stay fixed while it is high.
	logic capture;
	logic early;
	logic lkBusy;
	logic [3:0] firstN;
	logic [23:0] capA;
	logic [23:0] nextA;

	always_comb begin
		nxt_lk = lk_ff;
		nxt_lk.runS = {lk_ff.runS[0], st_ff.runQ};
		nxt_lk.suspS = {lk_ff.suspS[0], st_ff.suspQ};
		nxt_lk.modeS = {lk_ff.modeS[0], syncMode};
		nxt_lk.earlyS = {lk_ff.earlyS[0], ready_timing_select};
		nxt_lk.pollS = {lk_ff.pollS[0], pollInv};
		nxt_lk.codeS = {lk_ff.codeS[0],
			{wait_code_bit3, wait_code_bit2, wait_code_bit1, wait_code_bit0}};
		nxt_lk.bankS = {lk_ff.bankS[0], st_ff.opAddr[`BANK_MSB:`BANK_LSB]};
		nxt_lk.sectS = {lk_ff.sectS[0], st_ff.opAddr[`SECTOR_MSB:`SECTOR_LSB]};
		early = lk_ff.earlyS[1];
		capA = {addrHi, adqIn};
		nextA = lk_ff.addr + 24'h000001;
		firstN = firstEdge(lk_ff.codeS[1]);
		capture = lk_ff.modeS[1] & ~address_valid_strobe_n & ~chipSelectN;
		lkBusy = lk_ff.runS[1] && capA[`BANK_MSB:`BANK_LSB] == lk_ff.bankS[1];
		nxt_lk.rdyOe = lk_ff.modeS[1] & ~chipSelectN;
		nxt_lk.doe = 1'b0;
		unique case (lk_ff.bst)
			flash_status_pkg::B_IDLE: begin
				nxt_lk.rdy = 1'b0;
				if (capture) begin
					nxt_lk.addr = capA;
					nxt_lk.fetch = capA;
					nxt_lk.cnt = firstN - 4'h2;
					nxt_lk.rdy = early && firstN == 4'h2;
					nxt_lk.bst = flash_status_pkg::B_WAIT;
					nxt_lk.isStatus = lkBusy;
					if (lkBusy) begin
						nxt_lk.t6 = ~lk_ff.t6;
					end else if (lk_ff.suspS[1]
						&& capA[`SECTOR_MSB:`SECTOR_LSB] == lk_ff.sectS[1]) begin
						nxt_lk.t2 = ~lk_ff.t2;
						nxt_lk.isStatus = 1'b1;
					end
				end
			end
			flash_status_pkg::B_WAIT: begin
				nxt_lk.doe = ~outputEnableN;
				if (lk_ff.cnt == 4'h0) begin
					nxt_lk.bst = flash_status_pkg::B_DATA;
					// early ready must already drop when the next word is a stall
					nxt_lk.rdy = ~(early && nextA[6:0] == `BOUNDARY_LOW);
					nxt_lk.fetch = nextA;
					nxt_lk.dout = lk_ff.isStatus
						? statusWord(lk_ff.pollS[1], lk_ff.t6, lk_ff.t2)
						: burstArrayData;
				end else begin
					nxt_lk.cnt = lk_ff.cnt - 4'h1;
					nxt_lk.rdy = early && lk_ff.cnt == 4'h1;
				end
			end
			flash_status_pkg::B_DATA: begin
				nxt_lk.doe = ~outputEnableN;
				nxt_lk.addr = nextA;
				if (nextA[6:0] == `BOUNDARY_LOW) begin
					// crossing a 128-word line refetches; ready drops for the stall
					nxt_lk.bst = flash_status_pkg::B_BOUND;
					nxt_lk.cnt = `BOUNDARY_WAIT - 4'h1;
					nxt_lk.rdy = early && `BOUNDARY_WAIT == 4'h1;
				end else begin
					nxt_lk.fetch = nextA + 24'h000001;
					nxt_lk.rdy = ~(early && (nextA[6:0] + 7'h01) == `BOUNDARY_LOW);
					if (!lk_ff.isStatus) begin
						nxt_lk.dout = burstArrayData;
					end
				end
			end
			flash_status_pkg::B_BOUND: begin
				nxt_lk.doe = ~outputEnableN;
				if (lk_ff.cnt == 4'h0) begin
					nxt_lk.bst = flash_status_pkg::B_DATA;
					nxt_lk.rdy = ~(early && nextA[6:0] == `BOUNDARY_LOW);
					nxt_lk.fetch = nextA;
					if (!lk_ff.isStatus) begin
						nxt_lk.dout = burstArrayData;
					end
				end else begin
					nxt_lk.cnt = lk_ff.cnt - 4'h1;
					nxt_lk.rdy = early && lk_ff.cnt == 4'h1;
				end
			end
		endcase
		if (chipSelectN || !lk_ff.modeS[1]) begin
			nxt_lk.bst = flash_status_pkg::B_IDLE;
			nxt_lk.rdy = 1'b0;
			nxt_lk.doe = 1'b0;
		end
	end

	always_ff @(posedge linkClk or posedge sys_rst) begin
		if (sys_rst) begin
			lk_ff <= '0;
			lk_ff.bst <= flash_status_pkg::B_IDLE;
		end else begin
			lk_ff <= nxt_lk;
		end
	end

	assign burstAdqOut = lk_ff.dout;
	assign burstAdqOe = lk_ff.doe;
	assign rdyOut = lk_ff.rdy;
	assign rdyOe = lk_ff.rdyOe;
	assign burstArrayAddr = lk_ff.fetch;

endmodule : flash_status_poll_burst_latency

// [verification/flash_host_model.sv]
`timescale 1ns/100ps
module flash_host_model (
	input wire logic clk,
	input wire logic linkClk,
	output logic address_valid_strobe_n,
	output logic chipSelectN,
	output logic outputEnableN,
	output logic writeEnableN,
	output logic [7:0] addrHi,
	output logic [15:0] hostAdq
);
	initial begin
		address_valid_strobe_n = 1'b1;
		chipSelectN = 1'b1;
		outputEnableN = 1'b1;
		writeEnableN = 1'b1;
		{addrHi, hostAdq} = 24'h000000;
	end
	// address held 3 clks past the strobe rise, the core samples pins late
	task automatic cyc(input logic [23:0] a, input logic [15:0] d, input logic wr);
		@(negedge clk);
		address_valid_strobe_n = 1'b0;
		chipSelectN = 1'b0;
		{addrHi, hostAdq} = a;
		@(negedge clk) address_valid_strobe_n = 1'b1;
		repeat (3) @(negedge clk);
		hostAdq = wr ? d : ~hostAdq;
		writeEnableN = !wr;
		outputEnableN = wr;
		repeat (8) @(negedge clk);
		writeEnableN = 1'b1;
		outputEnableN = 1'b1;
		repeat (3) @(negedge clk);
		hostAdq = ~hostAdq;
		chipSelectN = 1'b1;
		repeat (3) @(negedge clk);
	endtask : cyc
	task automatic burst(input logic [23:0] a);
		@(negedge linkClk);
		address_valid_strobe_n = 1'b0;
		chipSelectN = 1'b0;
		{addrHi, hostAdq} = a;
		@(negedge linkClk) address_valid_strobe_n = 1'b1;
		outputEnableN = 1'b0;
		hostAdq = ~hostAdq;
	endtask : burst
	task automatic bend();
		@(negedge linkClk) chipSelectN = 1'b1;
		outputEnableN = 1'b1;
	endtask : bend
endmodule : flash_host_model

// [verification/flash_status_monitor.sv]
`timescale 1ns/100ps
module flash_status_monitor #(
	parameter int PROTECT_CYCLES = 70000,
	parameter int SUSPEND_CYCLES = 5000
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic linkClk,
	input wire logic address_valid_strobe_n,
	input wire logic chipSelectN,
	input wire logic outputEnableN,
	input wire logic writeEnableN,
	input wire logic asyncAdqOe,
	input wire logic rdyOut,
	input wire logic syncMode,
	input wire logic ready_timing_select,
	input wire logic wait_code_bit3,
	input wire logic wait_code_bit2,
	input wire logic wait_code_bit1,
	input wire logic wait_code_bit0,
	input wire logic cmdWrite,
	input wire logic suspendReq,
	input wire logic opRunning,
	input wire logic opSuspended
);
	logic [15:0] haltCnt_ff;
	logic cap;
	assign cap = !address_valid_strobe_n && !chipSelectN && syncMode && !wait_code_bit3
		&& !wait_code_bit2 && !wait_code_bit1 && !wait_code_bit0;
	// cycles spent halting since a suspend request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			haltCnt_ff <= 16'h0000;
		else if (opRunning && (suspendReq || haltCnt_ff != 16'h0000))
			haltCnt_ff <= haltCnt_ff + 16'h0001;
		else
			haltCnt_ff <= 16'h0000;
	end
	a_cmd_single: assert property (@(posedge clk) disable iff (sys_rst)
		cmdWrite |=> !cmdWrite) else $error("write pulse too long");
	a_cmd_cause: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(writeEnableN) && !chipSelectN |-> ##[1:4] cmdWrite) else $error("write lost");
	a_read_start: assert property (@(posedge clk) disable iff (sys_rst)
		writeEnableN && !syncMode && !chipSelectN && $fell(outputEnableN)
		|-> ##[2:4] asyncAdqOe) else $error("read not answered");
	a_susp_excl: assert property (@(posedge clk) disable iff (sys_rst)
		!(opRunning && opSuspended)) else $error("run and suspend together");
	a_halt_time: assert property (@(posedge clk) disable iff (sys_rst)
		haltCnt_ff <= SUSPEND_CYCLES + 3) else $error("suspend too slow");
	a_rdy_idle: assert property (@(posedge linkClk) disable iff (sys_rst)
		chipSelectN |=> !rdyOut) else $error("ready while deselected");
	a_rdy_late: assert property (@(posedge linkClk) disable iff (sys_rst)
		cap && !ready_timing_select |=> !rdyOut ##1 rdyOut) else $error("late ready wrong");
	a_rdy_early: assert property (@(posedge linkClk) disable iff (sys_rst)
		cap && ready_timing_select |=> rdyOut) else $error("early ready wrong");
endmodule : flash_status_monitor
bind flash_status_poll_burst_latency flash_status_monitor #(.PROTECT_CYCLES(PROTECT_CYCLES),
	.SUSPEND_CYCLES(SUSPEND_CYCLES)) flash_status_monitor_i (.*);

// [verification/flash_status_poll_burst_latency_tb_top.sv]
`timescale 1ns/100ps
module flash_status_poll_burst_latency_tb_top;
	logic clk = 0, sys_rst = 1, linkClk = 0, linkRun = 1, syncMode = 0, ready_timing_select = 0;
	logic address_valid_strobe_n, chipSelectN, outputEnableN, writeEnableN, asyncAdqOe;
	logic burstAdqOe, rdyOut, rdyOe, cmdWrite, opRunning, opSuspended, opStart = 0;
	logic opIsErase, opProtected, opFinished = 0, suspendReq = 0, resumeReq = 0, oePrev = 0;
	logic rdyPrev;
	logic [7:0] addrHi;
	logic [15:0] hostAdq, adq, asyncAdqOut, burstAdqOut, arrayData, burstArrayData, cmdData;
	logic [15:0] opData = 16'h0012, lastRd, first;
	logic [23:0] arrayAddr, burstArrayAddr, cmdAddr, opAddr = 24'h000000, a;
	logic [31:0] rng = 32'h0000005d, expQ[$];
	logic [3:0] code = 4'hd;
	int error_cnt = 0, n_checks = 0, n, i, w, t0;
	localparam logic [15:0] K = 16'h5a3c;
	always #2 clk = ~clk;
	// link clock runs during reset and the burst tests, stands still during the async tests
	always #32 linkClk <= #1.3 linkRun & ~linkClk;
	assign adq = asyncAdqOe ? asyncAdqOut : (burstAdqOe ? burstAdqOut : hostAdq);
	assign arrayData = arrayAddr[15:0] ^ K;
	assign burstArrayData = burstArrayAddr[15:0] ^ K;
	flash_host_model flash_host_model_i (.*);
	flash_status_poll_burst_latency #(.PROTECT_CYCLES(200), .SUSPEND_CYCLES(4))
		flash_status_poll_burst_latency_i (.adqIn(adq), .wait_code_bit3(code[3]),
		.wait_code_bit2(code[2]), .wait_code_bit1(code[1]), .wait_code_bit0(code[0]), .*);
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic fl(input string s);
		error_cnt++;
		$display("mismatch at %0t: %s", $time, s);
	endtask : fl
	task automatic chk(input logic [15:0] g, input logic [15:0] m, input logic [15:0] v);
		n_checks++;
		if ((g & m) !== v) fl($sformatf("got %h want %h", g, v));
	endtask : chk
	task automatic rd(input logic [23:0] ad, input logic [15:0] m, input logic [15:0] v);
		expQ.push_back({m, v});
		flash_host_model_i.cyc(ad, 16'h0000, 1'b0);
	endtask : rd
	task automatic tg(input logic [23:0] ad, input int b);
		flash_host_model_i.cyc(ad, 16'h0000, 1'b0);
		first = lastRd;
		flash_host_model_i.cyc(ad, 16'h0000, 1'b0);
		chk(lastRd ^ first, 16'h0001 << b, 16'h0001 << b);
	endtask : tg
	task automatic start(input logic [23:0] ad, input logic er, input logic pr);
		@(negedge clk) {opAddr, opIsErase, opProtected, opStart} = {ad, er, pr, 1'b1};
		@(negedge clk) opStart = 1'b0;
	endtask : start
	// async reads: oldest note is the answer to the read now on the bus
	always @(negedge clk) begin
		oePrev <= asyncAdqOe;
		if (asyncAdqOe && !oePrev) begin
			lastRd = asyncAdqOut;
			if (expQ.size() > 0) chk(asyncAdqOut, expQ[0][31:16], expQ[0][15:0]);
			if (expQ.size() > 0) void'(expQ.pop_front());
		end
	end
	initial begin
		repeat (20) @(negedge clk);
		sys_rst = 0;
		linkRun = 0;
		flash_host_model_i.cyc(24'h123456, 16'hbeef, 1'b1);
		chk(cmdAddr[15:0] ^ cmdData, 16'hffff, 16'h3456 ^ 16'hbeef);
		rd(24'h123456, 16'hffff, 16'h3456 ^ K);
		start(24'h100040, 1'b0, 1'b0);
		rd(24'h100040, 16'h00c0, 16'h0080);
		rd(24'h100040, 16'h00c0, 16'h00c0);
		rd(24'h200000, 16'hffff, K);
		rd(24'h100040, 16'h00c0, 16'h0080);
		@(negedge clk) opFinished = 1;
		@(negedge clk) opFinished = 0;
		rd(24'h100040, 16'hffff, 16'h0040 ^ K);
		rd(24'h100040, 16'hffff, 16'h0040 ^ K);
		$display("program polling done");
		start(24'h300000, 1'b1, 1'b0);
		rd(24'h300100, 16'h00c0, 16'h0040);
		@(negedge clk) suspendReq = 1;
		@(negedge clk) suspendReq = 0;
		for (n = 0; n < 40 && opSuspended !== 1'b1; n++) @(negedge clk);
		chk({15'h0000, opSuspended}, 16'h0001, 16'h0001);
		if (n == 40) tally_and_finish();
		tg(24'h300200, 2);
		rd(24'h310000, 16'hffff, K);
		@(negedge clk) resumeReq = 1;
		@(negedge clk) resumeReq = 0;
		@(negedge clk) opFinished = 1;
		@(negedge clk) opFinished = 0;
		$display("erase suspend done");
		start(24'h400000, 1'b1, 1'b1);
		t0 = $time;
		tg(24'h400000, 6);
		for (n = 0; n < 300 && opRunning === 1'b1; n++) @(negedge clk);
		n = ($time - t0) / 4;
		chk(16'((n >= 198 && n <= 203)), 16'h0001, 16'h0001);
		rd(24'h400000, 16'hffff, K);
		$display("protected erase done");
		syncMode = 1;
		linkRun = 1;
		for (int c = 0; c < 16; c++) begin
			@(negedge linkClk) code = c[3:0];
			rng = xs(rng);
			ready_timing_select = rng[0];
			repeat (3) @(negedge linkClk);
			a = c[0] ? 24'hfffffd : 24'h00007d;
			n = c < 6 ? c + 2 : ((c > 7 && c < 14) ? c : 13);
			flash_host_model_i.burst(a);
			rdyPrev = rdyOut;
			w = 0;
			for (i = 1; i < 40 && w < 5; i++) begin
				@(negedge linkClk);
				if (ready_timing_select ? rdyPrev : rdyOut) begin
					chk(adq, 16'hffff, a[15:0] ^ K);
					if (w == 0) chk(16'(i), 16'hffff, 16'(n - 1));
					chk({14'h0000, rdyOe, burstAdqOe}, 16'h0003, 16'h0003);
					a = a + 24'h000001;
					w++;
				end
				rdyPrev = rdyOut;
			end
			chk(16'(i - 1), 16'hffff, 16'(n + 5));
			if (w < 5) fl("burst timed out");
			if (w < 5) tally_and_finish();
			flash_host_model_i.bend();
		end
		$display("burst latency done");
		tally_and_finish();
	end
endmodule : flash_status_poll_burst_latency_tb_top
